// *** hdl/iuv_defs.vh ***
// Constants for the input undervoltage trip and response block
`ifndef IUV_DEFS_VH
`define IUV_DEFS_VH

`define IUV_ADDR_W 16
`define IUV_DATA_W 16

`define IUV_ADDR_ALERT 16'h0058
`define IUV_ADDR_TRIP 16'h0059
`define IUV_ADDR_ACTION 16'h005A
`define IUV_ADDR_EXP 16'hFE39
`define IUV_ADDR_IRQ_STAT 16'hFE40
`define IUV_ADDR_IRQ_CLR 16'hFE41
`define IUV_ADDR_IRQ_EN 16'hFE42
`define IUV_ADDR_STATE 16'hFE43

`define IUV_LVL_EXP 15:11
`define IUV_LVL_MANT 10:0
`define IUV_EXP_FLD 5:3
`define IUV_ACT_RESP 7:6
`define IUV_ACT_RETRY 5:3
`define IUV_ACT_DELAY 2:0

`define IUV_EXP_PAD 2'h0
`define IUV_RD_ZERO 16'h0000

`define IUV_RESP_NONE 2'h0
`define IUV_RESP_DELAYED 2'h1
`define IUV_RESP_IMMED 2'h2
`define IUV_RESP_HOLD 2'h3
`define IUV_RETRY_INF 3'h7

`define IUV_MANT_RST 11'h000
`define IUV_ACT_RST 8'h00
`define IUV_EXP_RST 3'h0
`define IUV_IRQ_RST 4'h0
`define IUV_RETRY_RST 3'h0

`define IUV_IRQ_FAULT 0
`define IUV_IRQ_WARN 1
`define IUV_IRQ_SHUT 2
`define IUV_IRQ_LATCH 3

`define IUV_CLK_KHZ 250000
`define IUV_TICK_MS 1
`define IUV_MS_CYCLES (`IUV_CLK_KHZ * `IUV_TICK_MS)

`define IUV_D1_0_MS 12'd10
`define IUV_D1_1_MS 12'd20
`define IUV_D1_2_MS 12'd40
`define IUV_D1_3_MS 12'd80
`define IUV_D1_4_MS 12'd160
`define IUV_D1_5_MS 12'd320
`define IUV_D1_6_MS 12'd640
`define IUV_D1_7_MS 12'd1280

`define IUV_D2_0_MS 12'd252
`define IUV_D2_1_MS 12'd558
`define IUV_D2_2_MS 12'd924
`define IUV_D2_3_MS 12'd1260
`define IUV_D2_4_MS 12'd1596
`define IUV_D2_5_MS 12'd1932
`define IUV_D2_6_MS 12'd2268
`define IUV_D2_7_MS 12'd2604

`endif

// *** hdl/iuv_delay_timer.v ***
// Millisecond delay timer with its own prescaler, restarted on every start
module iuv_delay_timer #(
  parameter MS_CYCLES = 250000,
  parameter PRE_W = 24,
  parameter MS_W = 12
) (
  input wire clock,
  input wire rst,
  input wire start,
  input wire [MS_W-1:0] load_ms,
  output reg done
);
  localparam [31:0] PRE_LAST_W = MS_CYCLES - 1;
  localparam [PRE_W-1:0] PRE_LAST = PRE_LAST_W[PRE_W-1:0];
  localparam [PRE_W-1:0] PRE_ZERO = 0;
  localparam [MS_W-1:0] MS_ZERO = 0;
  localparam [MS_W-1:0] MS_ONE = 1;

  reg [PRE_W-1:0] pre;
  reg [MS_W-1:0] ms_left;
  wire wrap = (pre == PRE_LAST);

  // Prescaler restarts with the timer so a delay is never cut short
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pre <= PRE_ZERO;
      ms_left <= MS_ZERO;
      done <= 1'b0;
    end else if (start) begin
      pre <= PRE_ZERO;
      ms_left <= load_ms;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (ms_left != MS_ZERO) begin
        pre <= wrap ? PRE_ZERO : pre + 1'b1;
        if (wrap) begin
          ms_left <= ms_left - 1'b1;
          done <= (ms_left == MS_ONE);
        end
      end
    end
  end
endmodule // iuv_delay_timer

// *** hdl/iuv_top.v ***
// Input undervoltage limit registers and fault response sequencer
//
// Our own choice: the address-and-strobe port.
`include "iuv_defs.vh"

module iuv_top #(
  parameter MS_CYCLES = `IUV_MS_CYCLES,
  parameter MANT_W = 11
) (
  input wire CLOCK,
  input wire SYS_RST,
  input wire [`IUV_ADDR_W-1:0] ADDR,
  input wire [`IUV_DATA_W-1:0] WR_DATA,
  input wire WR_STB,
  input wire RD_STB,
  output reg [`IUV_DATA_W-1:0] RD_DATA,
  input wire [MANT_W-1:0] VIN_MANT,
  output reg OUTPUT_EN,
  output reg UV_FAULT,
  output reg UV_WARN,
  output reg IRQ
);
  localparam [4:0] ST_RUN = 5'h01;
  localparam [4:0] ST_DELAY = 5'h02;
  localparam [4:0] ST_RETRY = 5'h04;
  localparam [4:0] ST_HOLD = 5'h08;
  localparam [4:0] ST_LATCH = 5'h10;
  localparam [7:0] ACT_PAD = 8'h00;
  localparam [9:0] EXP_HI_PAD = 10'h000;
  localparam [2:0] EXP_LO_PAD = 3'h0;
  localparam [11:0] IRQ_PAD = 12'h000;
  localparam [2:0] STATE_MID_PAD = 3'h0;
  localparam [3:0] STATE_LO_PAD = 4'h0;
  localparam [3:0] IRQ_NONE = 4'h0;

  reg [MANT_W-1:0] alert_mant;
  reg [MANT_W-1:0] trip_mant;
  reg [7:0] action;
  reg [2:0] exp_n;
  reg [3:0] irq_stat;
  reg [3:0] irq_en;
  reg [4:0] state;
  reg [2:0] retries;

  reg [4:0] next_state;
  reg [2:0] next_retries;
  reg tmr_start;
  reg [11:0] tmr_load;
  reg shut_evt;
  reg latch_evt;
  reg [`IUV_DATA_W-1:0] rd_mux;
  reg [3:0] next_irq_stat;

  wire tmr_done;
  wire [1:0] resp = action[`IUV_ACT_RESP];
  wire [2:0] retry_set = action[`IUV_ACT_RETRY];
  wire [2:0] delay_sel = action[`IUV_ACT_DELAY];
  wire [4:0] exp_field = {`IUV_EXP_PAD, exp_n};

  wire wr_alert = WR_STB && (ADDR == `IUV_ADDR_ALERT);
  wire wr_trip = WR_STB && (ADDR == `IUV_ADDR_TRIP);
  wire wr_action = WR_STB && (ADDR == `IUV_ADDR_ACTION);
  wire wr_exp = WR_STB && (ADDR == `IUV_ADDR_EXP);
  wire wr_clr = WR_STB && (ADDR == `IUV_ADDR_IRQ_CLR);
  wire wr_en = WR_STB && (ADDR == `IUV_ADDR_IRQ_EN);

  // compare levels
  // Both sides share one exponent, so only mantissas are compared
  wire fault_now = (VIN_MANT < trip_mant);
  wire warn_now = (VIN_MANT < alert_mant);

  function [11:0] delay1_ms;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: delay1_ms = `IUV_D1_0_MS;
        3'h1: delay1_ms = `IUV_D1_1_MS;
        3'h2: delay1_ms = `IUV_D1_2_MS;
        3'h3: delay1_ms = `IUV_D1_3_MS;
        3'h4: delay1_ms = `IUV_D1_4_MS;
        3'h5: delay1_ms = `IUV_D1_5_MS;
        3'h6: delay1_ms = `IUV_D1_6_MS;
        default: delay1_ms = `IUV_D1_7_MS;
      endcase
    end
  endfunction

  function [11:0] delay2_ms;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: delay2_ms = `IUV_D2_0_MS;
        3'h1: delay2_ms = `IUV_D2_1_MS;
        3'h2: delay2_ms = `IUV_D2_2_MS;
        3'h3: delay2_ms = `IUV_D2_3_MS;
        3'h4: delay2_ms = `IUV_D2_4_MS;
        3'h5: delay2_ms = `IUV_D2_5_MS;
        3'h6: delay2_ms = `IUV_D2_6_MS;
        default: delay2_ms = `IUV_D2_7_MS;
      endcase
    end
  endfunction

  iuv_delay_timer #(
    .MS_CYCLES(MS_CYCLES),
    .PRE_W(24),
    .MS_W(12)
  ) u_timer (
    .clock(CLOCK),
    .rst(SYS_RST),
    .start(tmr_start),
    .load_ms(tmr_load),
    .done(tmr_done)
  );

  // writable mantissas
  // Writes to the exponent bits of a level register are dropped
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      alert_mant <= `IUV_MANT_RST;
    end else if (wr_alert) begin
      alert_mant <= WR_DATA[`IUV_LVL_MANT];
    end
  end

  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      trip_mant <= `IUV_MANT_RST;
    end else if (wr_trip) begin
      trip_mant <= WR_DATA[`IUV_LVL_MANT];
    end
  end

  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      action <= `IUV_ACT_RST;
    end else if (wr_action) begin
      action <= WR_DATA[7:0];
    end
  end

  // One exponent serves both level registers
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      exp_n <= `IUV_EXP_RST;
    end else if (wr_exp) begin
      exp_n <= WR_DATA[`IUV_EXP_FLD];
    end
  end

  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_en <= `IUV_IRQ_RST;
    end else if (wr_en) begin
      irq_en <= WR_DATA[3:0];
    end
  end

  always @* begin
    rd_mux = `IUV_RD_ZERO;
    case (ADDR)
      `IUV_ADDR_ALERT: rd_mux = {exp_field, alert_mant};
      `IUV_ADDR_TRIP: rd_mux = {exp_field, trip_mant};
      `IUV_ADDR_ACTION: rd_mux = {ACT_PAD, action};
      `IUV_ADDR_EXP: rd_mux = {EXP_HI_PAD, exp_n, EXP_LO_PAD};
      `IUV_ADDR_IRQ_STAT: rd_mux = {IRQ_PAD, irq_stat};
      `IUV_ADDR_IRQ_EN: rd_mux = {IRQ_PAD, irq_en};
      `IUV_ADDR_STATE: rd_mux = {retries, STATE_MID_PAD, OUTPUT_EN, state, STATE_LO_PAD};
      default: rd_mux = `IUV_RD_ZERO;
    endcase
  end

  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RD_DATA <= `IUV_RD_ZERO;
    end else begin
      RD_DATA <= RD_STB ? rd_mux : `IUV_RD_ZERO;
    end
  end

  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      UV_FAULT <= 1'b0;
    end else begin
      UV_FAULT <= fault_now;
    end
  end

  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      UV_WARN <= 1'b0;
    end else begin
      UV_WARN <= warn_now;
    end
  end

  // Response sequencer
  always @* begin
    next_state = state;
    next_retries = retries;
    tmr_start = 1'b0;
    tmr_load = delay2_ms(delay_sel);
    shut_evt = 1'b0;
    latch_evt = 1'b0;
    case (state)
      ST_RUN: begin
        if (!UV_FAULT) begin
          next_retries = `IUV_RETRY_RST;
        end else begin
          case (resp)
            `IUV_RESP_DELAYED: begin
              next_state = ST_DELAY;
              tmr_start = 1'b1;
              tmr_load = delay1_ms(delay_sel);
            end
            `IUV_RESP_IMMED: begin
              shut_evt = 1'b1;
            end
            `IUV_RESP_HOLD: begin
              next_state = ST_HOLD;
            end
            default: begin
              next_state = ST_RUN;
            end
          endcase
        end
      end
      ST_DELAY: begin
        if (!UV_FAULT) begin
          next_state = ST_RUN;
        end else if (tmr_done) begin
          shut_evt = 1'b1;
        end
      end
      ST_RETRY: begin
        if (tmr_done) begin
          next_state = ST_RUN;
        end
      end
      ST_HOLD: begin
        if (!UV_FAULT) begin
          next_state = ST_RUN;
        end
      end
      ST_LATCH: begin
        next_state = ST_LATCH;
      end
      default: begin
        next_state = ST_LATCH;
      end
    endcase
    if (shut_evt) begin
      // count attempts, latch when used up
      if ((retry_set != `IUV_RETRY_INF) && (retries >= retry_set)) begin
        next_state = ST_LATCH;
        latch_evt = 1'b1;
      end else begin
        next_state = ST_RETRY;
        tmr_start = 1'b1;
        tmr_load = delay2_ms(delay_sel);
        if (retry_set != `IUV_RETRY_INF) begin
          next_retries = retries + 1'b1;
        end
      end
    end
  end

  // state and output enable, reset to ST_RUN with the output enabled
  wire next_output_en = (next_state == ST_RUN) || (next_state == ST_DELAY);
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      retries <= `IUV_RETRY_RST;
    end else begin
      retries <= next_retries;
    end
  end

  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      OUTPUT_EN <= 1'b1;
    end else begin
      OUTPUT_EN <= next_output_en;
    end
  end

  // Sticky status: a new event wins over a clear in the same cycle
  wire [3:0] irq_set = {latch_evt, shut_evt, warn_now & ~UV_WARN, fault_now & ~UV_FAULT};
  wire [3:0] irq_clr = wr_clr ? WR_DATA[3:0] : IRQ_NONE;

  always @* begin
    next_irq_stat = (irq_stat & ~irq_clr) | irq_set;
  end

  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_stat <= `IUV_IRQ_RST;
    end else begin
      irq_stat <= next_irq_stat;
    end
  end

  // IRQ follows the status it will show, so both change on one edge
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(next_irq_stat & irq_en);
    end
  end
endmodule // iuv_top

// *** bench/iuv_vin_src.sv ***
// Input voltage source model feeding the measured mantissa
module iuv_vin_src (
  input wire clock,
  input wire [10:0] level,
  output reg [10:0] vin_mant
);
  timeunit 1ns;
  timeprecision 1ps;
  initial vin_mant = 11'h7FF;
  // Refreshed once a cycle, like a sampled converter result
  always @(posedge clock) begin
    vin_mant <= level;
  end
endmodule // iuv_vin_src

// *** bench/iuv_top_props.sv ***
// Port-level assertions for the undervoltage trip block
module iuv_top_props #(
  parameter MANT_W = 11
) (
  input wire CLOCK,
  input wire SYS_RST,
  input wire [15:0] ADDR,
  input wire [15:0] WR_DATA,
  input wire WR_STB,
  input wire RD_STB,
  input wire [15:0] RD_DATA,
  input wire [MANT_W-1:0] VIN_MANT,
  input wire OUTPUT_EN,
  input wire UV_FAULT,
  input wire UV_WARN,
  input wire IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [MANT_W-1:0] trip;
  reg [MANT_W-1:0] alert;
  reg [7:0] act;
  // Shadows rebuilt from bus writes, since the checker sees no internals
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      trip <= {MANT_W{1'b0}};
      alert <= {MANT_W{1'b0}};
      act <= 8'h00;
    end else if (WR_STB) begin
      if (ADDR == 16'h0059) trip <= WR_DATA[MANT_W-1:0];
      if (ADDR == 16'h0058) alert <= WR_DATA[MANT_W-1:0];
      if (ADDR == 16'h005A) act <= WR_DATA[7:0];
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  a_read_idle: assert property (!$past(RD_STB) |-> RD_DATA == 16'h0000)
    else $error("read data not idle");
  a_trip_mirror: assert property ($past(RD_STB) && $past(ADDR) == 16'h0059 |->
    RD_DATA[15:14] == 2'h0 && RD_DATA[10:0] == $past(trip)) else $error("trip read wrong");
  a_fault_cmp: assert property (UV_FAULT == $past(VIN_MANT < trip))
    else $error("fault compare wrong");
  a_warn_cmp: assert property (UV_WARN == $past(VIN_MANT < alert))
    else $error("warn compare wrong");
  a_none_runs: assert property (act[7:6] == 2'h0 && $stable(act) && OUTPUT_EN |=> OUTPUT_EN)
    else $error("output dropped with no action");
  a_immed_shut: assert property (act[7:6] == 2'h2 && UV_FAULT && OUTPUT_EN |=> !OUTPUT_EN)
    else $error("no immediate shutdown");
  a_delay_hold: assert property (act[7:6] == 2'h1 && $rose(UV_FAULT) && OUTPUT_EN
    |=> OUTPUT_EN [*8]) else $error("delayed shutdown too early");
  a_retry_gap: assert property (act[7:6] == 2'h2 && $fell(OUTPUT_EN) |-> !OUTPUT_EN [*8])
    else $error("restart too soon");
  a_hold_clear: assert property (act[7:6] == 2'h3 && !UV_FAULT && !OUTPUT_EN
    |-> ##[1:2] OUTPUT_EN) else $error("no restart after clear");
  a_reset_out: assert property ($fell(SYS_RST) |-> OUTPUT_EN && !IRQ && !UV_FAULT)
    else $error("reset state wrong");
  c_immed: cover property (act[7:6] == 2'h2 && $fell(OUTPUT_EN));
  c_delay: cover property (act[7:6] == 2'h1 && $fell(OUTPUT_EN));
  c_irq: cover property ($rose(IRQ));
endmodule // iuv_top_props
bind iuv_top iuv_top_props #(.MANT_W(MANT_W)) u_props (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
  .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA),
  .VIN_MANT(VIN_MANT), .OUTPUT_EN(OUTPUT_EN), .UV_FAULT(UV_FAULT), .UV_WARN(UV_WARN), .IRQ(IRQ));

// *** bench/iuv_top_test.sv ***
// Self-checking bench for the undervoltage trip block
module iuv_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  // Short millisecond keeps the long delay tables affordable
  localparam int MS = 4;
  reg CLOCK = 1'b0;
  reg SYS_RST = 1'b1;
  reg [15:0] ADDR = 16'h0000;
  reg [15:0] WR_DATA = 16'h0000;
  reg WR_STB = 1'b0;
  reg RD_STB = 1'b0;
  reg [10:0] level = 11'h7FF;
  wire [15:0] RD_DATA;
  wire [10:0] VIN_MANT;
  wire OUTPUT_EN, UV_FAULT, UV_WARN, IRQ;
  int fail_count = 0;
  int checked = 0;
  int n;
  reg [15:0] rv;
  always #2 CLOCK = ~CLOCK;
  iuv_top #(.MS_CYCLES(MS)) dut_u (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .ADDR(ADDR),
    .WR_DATA(WR_DATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA),
    .VIN_MANT(VIN_MANT), .OUTPUT_EN(OUTPUT_EN), .UV_FAULT(UV_FAULT), .UV_WARN(UV_WARN),
    .IRQ(IRQ));
  iuv_vin_src src_u (.clock(CLOCK), .level(level), .vin_mant(VIN_MANT));
  task chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task test_done;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task settle(input int k);
    repeat (k) @(posedge CLOCK);
    #1;
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    WR_DATA <= d;
    WR_STB <= 1'b1;
    @(posedge CLOCK);
    WR_STB <= 1'b0;
  endtask
  task rdc(input string name, input logic [15:0] a, input logic [15:0] exp);
    @(posedge CLOCK);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge CLOCK);
    RD_STB <= 1'b0;
    #1 rv = RD_DATA;
    chk(name, rv, exp);
  endtask
  task setv(input logic [10:0] v);
    @(posedge CLOCK);
    level <= v;
    settle(4);
  endtask
  task wait_en(input logic v, input int lim);
    n = 0;
    while (OUTPUT_EN !== v && n < lim) begin
      settle(1);
      n++;
    end
  endtask
  task rst;
    @(posedge CLOCK);
    SYS_RST <= 1'b1;
    @(posedge CLOCK);
    SYS_RST <= 1'b0;
    settle(1);
    chk("out", OUTPUT_EN, 1'b1);
    rdc("state", 16'hFE43, 16'h0210);
    wr(16'h0059, 16'h0100);
  endtask
  initial begin
    repeat (8) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    rdc("alert", 16'h0058, 16'h0000);
    rdc("trip", 16'h0059, 16'h0000);
    rdc("state", 16'hFE43, 16'h0210);
    rdc("unmapped", 16'h0000, 16'h0000);
    wr(16'hFE39, 16'h0028);
    wr(16'h0059, 16'hFFFF);
    rdc("trip", 16'h0059, 16'h2FFF);
    rdc("exp", 16'hFE39, 16'h0028);
    wr(16'h0058, 16'h0123);
    rdc("alert", 16'h0058, 16'h2923);
    for (int i = 0; i < 8; i++) begin
      wr(16'h005A, {10'h000, i[2:0], 3'h5});
      rdc("action", 16'h005A, {10'h000, i[2:0], 3'h5});
    end
    wr(16'h0059, 16'h0100);
    rdc("trip", 16'h0059, 16'h2900);
    wr(16'h0058, 16'h0200);
    wr(16'hFE42, 16'h0002);
    setv(11'h150);
    chk("warn", UV_WARN, 1'b1);
    chk("irq", IRQ, 1'b1);
    wr(16'hFE41, 16'h0002);
    rdc("status", 16'hFE40, 16'h0000);
    chk("irq", IRQ, 1'b0);
    setv(11'h050);
    chk("fault", UV_FAULT, 1'b1);
    chk("irq", IRQ, 1'b0);
    rdc("status", 16'hFE40, 16'h0001);
    wr(16'hFE42, 16'h000F);
    settle(2);
    chk("irq", IRQ, 1'b1);
    chk("out", OUTPUT_EN, 1'b1);
    wr(16'hFE41, 16'h000F);
    setv(11'h300);
    wr(16'h005A, 16'h0088);
    setv(11'h050);
    chk("out", OUTPUT_EN, 1'b0);
    wait_en(1'b1, 3000);
    chk("gap", n >= 252 * MS - 2 && n <= 252 * MS + 8, 1'b1);
    settle(4);
    chk("out", OUTPUT_EN, 1'b0);
    rdc("status", 16'hFE40, 16'h000F);
    rdc("state", 16'hFE43, 16'h2100);
    setv(11'h300);
    settle(60);
    chk("out", OUTPUT_EN, 1'b0);
    rst();
    wr(16'h005A, 16'h0040);
    setv(11'h050);
    setv(11'h300);
    settle(60);
    chk("out", OUTPUT_EN, 1'b1);
    setv(11'h050);
    wait_en(1'b0, 200);
    chk("delay", n >= 10 * MS - 4 && n <= 10 * MS + 6, 1'b1);
    wait_en(1'b1, 1200);
    chk("out", OUTPUT_EN, 1'b0);
    rst();
    wr(16'h005A, 16'h00C0);
    setv(11'h050);
    settle(20);
    chk("out", OUTPUT_EN, 1'b0);
    setv(11'h300);
    chk("out", OUTPUT_EN, 1'b1);
    test_done();
  end
  // Generous bound over the roughly two and a half thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge CLOCK);
    fail_count++;
    test_done();
  end
endmodule // iuv_top_test
